// *** rtl/rfg_params.svh ***
`ifndef RFG_PARAMS_SVH
`define RFG_PARAMS_SVH
// Register indices (printed offsets are not multiples of four)
`define RFG_IDX_GUARD_LOW 8'h32
`define RFG_IDX_FRAME_FMT 8'h33
`define RFG_IDX_SOF_DET 8'h34
`define RFG_IDX_RX_CTRL 8'h35
`define RFG_IDX_GUARD_CTRL 8'h31
`define RFG_IDX_EOF_SYM 8'h3A
`define RFG_IDX_ERROR 8'h3B
// Reset values
`define RFG_RST_GUARD_CTRL 8'hC0
`define RFG_RST_ZERO 8'h00
// Field positions
`define RFG_GC_ORIGIN 7
`define RFG_GC_UNIT 6
`define RFG_GC_HI_MSB 5
`define RFG_GC_HI_LSB 3
`define RFG_FF_TXPAR 7
`define RFG_FF_RXPAR 6
`define RFG_FF_STOP_MSB 3
`define RFG_FF_STOP_LSB 2
`define RFG_FF_START_MSB 1
`define RFG_FF_START_LSB 0
`define RFG_SD_SOF_EN 5
`define RFG_SD_SOF_SEEN 4
`define RFG_SD_SUBCARRIER_IRQ_ENABLE 2
`define RFG_SD_SUBC_SEEN 1
`define RFG_SD_SUBC_LIVE 0
`define RFG_RC_PARTIAL 7
`define RFG_RC_MULTI 6
`define RFG_RC_EOFTYPE 5
`define RFG_RC_GAPCHK 4
`define RFG_RC_EMD 3
`define RFG_RC_BAUD_MSB 2
`define RFG_RC_BAUD_LSB 0
// Timing: one carrier guard unit is 16 carrier periods
`define RFG_CARRIER_PER_UNIT 16
`define RFG_CARRIER_KHZ 13560
`define RFG_PCLK_KHZ 250000
`define RFG_UNIT_CYCLES ((`RFG_CARRIER_PER_UNIT * `RFG_PCLK_KHZ) / `RFG_CARRIER_KHZ)
`define RFG_EMD_BYTES 3'h3
`define RFG_GAP_LIMIT 12'h0_200
`endif

// *** rtl/rfg_pkg.sv ***
package rfg_pkg;
    typedef enum logic [1:0] {
        RFG_SYM_NONE,
        RFG_SYM_0,
        RFG_SYM_1,
        RFG_SYM_2
    } rfg_sym_t;
    typedef enum logic [1:0] {
        RFG_TX_IDLE,
        RFG_TX_START,
        RFG_TX_DATA,
        RFG_TX_STOP
    } rfg_tx_state_t;
endpackage

// *** rtl/rfg_guard_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rfg_params.svh"
// Guard counter: counts the 11-bit value down in the chosen unit
module rfg_guard_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pce,
    input wire logic load,
    input wire logic [10:0] guard_value,
    input wire logic unit_bits,
    input wire logic half_bit_tick,
    output logic busy
);
    import rfg_pkg::*;
    logic [10:0] remain;
    logic [8:0] pre;
    // Carrier unit tick from a prescaler wide enough for the unit count
    wire carrier_tick = (pre == 9'(`RFG_UNIT_CYCLES - 1));
    wire unit_tick = unit_bits ? half_bit_tick : carrier_tick;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre <= 9'h000;
        end else if (pce) begin
            pre <= (load || carrier_tick) ? 9'h000 : pre + 9'h001;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remain <= 11'h000;
        end else if (pce) begin
            if (load) begin
                remain <= guard_value;
            end else if (unit_tick && remain != 11'h000) begin
                remain <= remain - 11'h001;
            end
        end
    end
    assign busy = (remain != 11'h000);
endmodule
`default_nettype wire

// *** rtl/rfg_parity.sv ***
`timescale 1ns/1ps
`default_nettype none
// Odd parity over one byte
module rfg_parity (
    input wire logic [7:0] data,
    output logic odd_bit
);
    assign odd_bit = ~(^data);
endmodule
`default_nettype wire

// *** rtl/rfg_frame_guard.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rfg_params.svh"
module rfg_frame_guard (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tx_request,
    input wire logic [7:0] tx_byte,
    input wire logic tx_last,
    input wire logic tx_byte_done,
    input wire logic half_bit_tick,
    input wire logic rx_sof,
    input wire logic rx_subcarrier,
    input wire logic rx_byte_valid,
    input wire logic [8:0] rx_byte,
    input wire logic rx_partial,
    input wire logic rx_error,
    input wire logic rx_end,
    input wire logic rx_char_gap,
    input wire logic crc_enable,
    output logic tx_start,
    output rfg_pkg::rfg_sym_t tx_symbol,
    output logic tx_symbol_valid,
    output logic [8:0] tx_word,
    output logic tx_word_valid,
    output logic rx_parity_error,
    output logic fifo_write,
    output logic [7:0] fifo_data,
    output logic fifo_reset,
    output logic rx_active,
    output logic rx_irq,
    output logic rx_frame_start_interrupt,
    output logic protocol_error,
    output logic eof_check_enable,
    output logic eof_type_b,
    output logic [2:0] rx_baud_code
);
    import rfg_pkg::*;
    // ========================================
    // Register bus
    logic [7:0] guard_low, guard_ctrl, frame_fmt, sof_det, rx_ctrl, eof_sym, err_reg;
    logic [2:0] emd_count;
    logic [11:0] gap_count;
    logic rx_live, subc_q;
    wire [7:0] reg_idx = paddr[9:2];
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire hit_low = reg_idx == `RFG_IDX_GUARD_LOW;
    wire hit_ctl = reg_idx == `RFG_IDX_GUARD_CTRL;
    wire hit_fmt = reg_idx == `RFG_IDX_FRAME_FMT;
    wire hit_sof = reg_idx == `RFG_IDX_SOF_DET;
    wire hit_rxc = reg_idx == `RFG_IDX_RX_CTRL;
    wire hit_eof = reg_idx == `RFG_IDX_EOF_SYM;
    wire hit_err = reg_idx == `RFG_IDX_ERROR;
    wire mapped = hit_low | hit_ctl | hit_fmt | hit_sof | hit_rxc | hit_eof | hit_err;
    wire aligned = paddr[1:0] == 2'b00 && paddr[31:10] == 22'h00_0000;
    wire ok = mapped && aligned;
    // Live subcarrier and status image with reserved bits zero
    wire [7:0] sof_view = {2'b00, sof_det[`RFG_SD_SOF_EN], sof_det[`RFG_SD_SOF_SEEN], 1'b0,
        sof_det[`RFG_SD_SUBCARRIER_IRQ_ENABLE], sof_det[`RFG_SD_SUBC_SEEN], subc_q};
    wire [7:0] rd_byte = hit_low ? guard_low : hit_ctl ? guard_ctrl :
        hit_fmt ? {frame_fmt[7:6], 2'b00, frame_fmt[3:0]} : hit_sof ? sof_view :
        hit_rxc ? rx_ctrl : hit_eof ? eof_sym : hit_err ? err_reg : 8'h00;
    // No wait state: answer registered from setup, ready in first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (pce) begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !ok;
            prdata <= (psel && !penable && ok) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end
    wire wr_done = wr && pready && !pslverr;
    // Writable configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            guard_low <= `RFG_RST_ZERO;
            guard_ctrl <= `RFG_RST_GUARD_CTRL;
            frame_fmt <= `RFG_RST_ZERO;
            rx_ctrl <= `RFG_RST_ZERO;
            eof_sym <= `RFG_RST_ZERO;
        end else if (pce && wr_done) begin
            if (hit_low) guard_low <= pwdata[7:0];
            if (hit_ctl) guard_ctrl <= pwdata[7:0];
            if (hit_fmt) frame_fmt <= {pwdata[7:6], 2'b00, pwdata[3:0]};
            if (hit_rxc) rx_ctrl <= pwdata[7:0];
            if (hit_eof) eof_sym <= pwdata[7:0];
        end
    end
    // ========================================
    // Start-of-frame and subcarrier flags
    wire sof_clr = wr_done && hit_sof && pwdata[`RFG_SD_SOF_SEEN];
    wire subc_clr = wr_done && hit_sof && pwdata[`RFG_SD_SUBC_SEEN];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sof_det <= `RFG_RST_ZERO;
            subc_q <= 1'b0;
        end else if (pce) begin
            subc_q <= rx_subcarrier;
            if (wr_done && hit_sof) begin
                sof_det[`RFG_SD_SOF_EN] <= pwdata[`RFG_SD_SOF_EN];
                sof_det[`RFG_SD_SUBCARRIER_IRQ_ENABLE] <= pwdata[`RFG_SD_SUBCARRIER_IRQ_ENABLE];
            end
            sof_det[`RFG_SD_SOF_SEEN] <= rx_sof | (sof_det[`RFG_SD_SOF_SEEN] & ~sof_clr);
            sof_det[`RFG_SD_SUBC_SEEN] <= rx_subcarrier |
                (sof_det[`RFG_SD_SUBC_SEEN] & ~subc_clr);
        end
    end
    wire next_sof_irq = (rx_sof && sof_det[`RFG_SD_SOF_EN]) ||
        (rx_subcarrier && !subc_q && sof_det[`RFG_SD_SUBCARRIER_IRQ_ENABLE]);
    // ========================================
    // Guard time
    // eleven-bit guard value
    wire [10:0] guard_value = {guard_ctrl[`RFG_GC_HI_MSB:`RFG_GC_HI_LSB], guard_low};
    wire guard_load = guard_ctrl[`RFG_GC_ORIGIN] ? rx_end : (tx_byte_done && tx_last);
    logic guard_busy;
    rfg_guard_timer u_guard (
        .pclk(pclk),
        .presetn(presetn),
        .pce(pce),
        .load(guard_load),
        .guard_value(guard_value),
        .unit_bits(guard_ctrl[`RFG_GC_UNIT]),
        .half_bit_tick(half_bit_tick),
        .busy(guard_busy)
    );
    // ========================================
    // Transmit framing
    rfg_tx_state_t tx_state;
    logic tx_par;
    rfg_parity u_txpar (
        .data(tx_byte),
        .odd_bit(tx_par)
    );
    wire rfg_sym_t start_sel = rfg_sym_t'(frame_fmt[`RFG_FF_START_MSB:`RFG_FF_START_LSB]);
    wire rfg_sym_t stop_sel = rfg_sym_t'(frame_fmt[`RFG_FF_STOP_MSB:`RFG_FF_STOP_LSB]);
    wire go = tx_request && !guard_busy && !guard_load;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state <= RFG_TX_IDLE;
            tx_start <= 1'b0;
            tx_symbol <= RFG_SYM_NONE;
            tx_symbol_valid <= 1'b0;
        end else if (pce) begin
            tx_start <= 1'b0;
            tx_symbol_valid <= 1'b0;
            unique case (tx_state)
                RFG_TX_IDLE: begin
                    if (go) begin
                        tx_start <= 1'b1;
                        tx_state <= RFG_TX_START;
                    end
                end
                RFG_TX_START: begin
                    tx_symbol <= start_sel;
                    tx_symbol_valid <= start_sel != RFG_SYM_NONE;
                    tx_state <= RFG_TX_DATA;
                end
                RFG_TX_DATA: begin
                    if (tx_byte_done && tx_last) tx_state <= RFG_TX_STOP;
                end
                RFG_TX_STOP: begin
                    tx_symbol <= stop_sel;
                    tx_symbol_valid <= stop_sel != RFG_SYM_NONE;
                    tx_state <= RFG_TX_IDLE;
                end
            endcase
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_word <= 9'h000;
            tx_word_valid <= 1'b0;
        end else if (pce) begin
            tx_word_valid <= tx_state == RFG_TX_DATA && tx_byte_done;
            tx_word <= frame_fmt[`RFG_FF_TXPAR] ? {tx_par, tx_byte} : {1'b0, tx_byte};
        end
    end
    // ========================================
    // Receive control
    logic rx_par;
    rfg_parity u_rxpar (
        .data(rx_byte[7:0]),
        .odd_bit(rx_par)
    );
    wire use_parity = frame_fmt[`RFG_FF_RXPAR];
    wire par_bad = rx_byte_valid && use_parity && !rx_partial && (rx_par != rx_byte[8]);
    wire emd_on = rx_ctrl[`RFG_RC_EMD];
    wire multi = rx_ctrl[`RFG_RC_MULTI];
    wire in_emd = emd_on && emd_count < `RFG_EMD_BYTES;
    wire bad_now = rx_error || par_bad;
    // early error discards and resets FIFO
    wire emd_hit = in_emd && bad_now;
    wire emd_short = in_emd && rx_end;
    // partial bytes pass only when allowed with checksum on
    wire keep_byte = rx_byte_valid && !emd_hit &&
        (!rx_partial || !crc_enable || rx_ctrl[`RFG_RC_PARTIAL]);
    // extra guard time checked for type B
    wire gap_long = rx_ctrl[`RFG_RC_GAPCHK] && rx_ctrl[`RFG_RC_EOFTYPE] &&
        gap_count == `RFG_GAP_LIMIT;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            emd_count <= 3'h0;
            gap_count <= 12'h000;
            rx_live <= 1'b0;
            err_reg <= `RFG_RST_ZERO;
        end else if (pce) begin
            if (rx_sof || emd_hit) emd_count <= 3'h0;
            else if (rx_byte_valid && emd_count < `RFG_EMD_BYTES) emd_count <= emd_count + 3'h1;
            gap_count <= (rx_char_gap && !gap_long) ? gap_count + 12'h001 : 12'h000;
            if (rx_sof) rx_live <= 1'b1;
            else if (rx_end && !multi) rx_live <= 1'b0;
            if (rx_sof) err_reg <= 8'h00;
            else err_reg <= err_reg | {5'b0, gap_long, par_bad, rx_error && !emd_hit};
        end
    end
    // Registered receive outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fifo_write <= 1'b0;
            fifo_data <= 8'h00;
            fifo_reset <= 1'b0;
            rx_irq <= 1'b0;
            rx_parity_error <= 1'b0;
            protocol_error <= 1'b0;
            rx_frame_start_interrupt <= 1'b0;
        end else if (pce) begin
            // error copy appended at stream end
            fifo_write <= keep_byte || (rx_end && multi && !emd_short);
            fifo_data <= keep_byte ? rx_byte[7:0] : err_reg;
            fifo_reset <= emd_hit;
            rx_irq <= rx_end && !emd_short && !emd_hit;
            rx_parity_error <= par_bad;
            protocol_error <= gap_long;
            rx_frame_start_interrupt <= next_sof_irq;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eof_type_b <= 1'b0;
            eof_check_enable <= 1'b0;
            rx_baud_code <= 3'h0;
            rx_active <= 1'b0;
        end else if (pce) begin
            eof_type_b <= rx_ctrl[`RFG_RC_EOFTYPE];
            eof_check_enable <= rx_ctrl[`RFG_RC_EOFTYPE] || (eof_sym[1:0] != 2'b00);
            rx_baud_code <= rx_ctrl[`RFG_RC_BAUD_MSB:`RFG_RC_BAUD_LSB];
            rx_active <= rx_live;
        end
    end
    // ========================================
    // Checks
    // flag set after detection
    sof_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
        pce && rx_sof |=> sof_det[`RFG_SD_SOF_SEEN])
        else $error("start flag not set");
    subc_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
        pce && rx_subcarrier |=> sof_det[`RFG_SD_SUBC_SEEN])
        else $error("subcarrier flag not set");
    guard_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        pce && guard_busy && tx_state == RFG_TX_IDLE |=> !tx_start)
        else $error("transmit began during guard");
    sof_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
        pce && rx_sof && sof_det[`RFG_SD_SOF_EN] |=> rx_frame_start_interrupt)
        else $error("frame start interrupt missing");
    emd_noirq_a: assert property (@(posedge pclk) disable iff (!presetn)
        pce && emd_short |=> !rx_irq)
        else $error("receive interrupt in disturbance case");
    emd_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
        pce && emd_hit |=> fifo_reset && !fifo_write)
        else $error("early error not discarded");
    eof_skip_a: assert property (@(posedge pclk) disable iff (!presetn)
        pce && !rx_ctrl[`RFG_RC_EOFTYPE] && eof_sym[1:0] == 2'b00 |=> !eof_check_enable)
        else $error("end check not skipped");
    tx_parity_a: assert property (@(posedge pclk) disable iff (!presetn)
        pce && frame_fmt[`RFG_FF_TXPAR] |=> tx_word[8] == ~(^tx_word[7:0]))
        else $error("transmit parity wrong");
endmodule
`default_nettype wire

// *** test/rfg_card_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Card side of the air link
module rfg_card_model (
    input wire logic pclk,
    input wire logic [8:0] tx_word,
    input wire logic tx_word_valid,
    output logic rx_sof,
    output logic rx_subcarrier,
    output logic rx_byte_valid,
    output logic [8:0] rx_byte,
    output logic rx_partial,
    output logic rx_error,
    output logic rx_end,
    output logic rx_char_gap
);
    logic [8:0] last_word = 9'h000;

    // Quiet link until the first event
    initial begin
        rx_sof <= 1'b0;
        rx_subcarrier <= 1'b0;
        rx_byte_valid <= 1'b0;
        rx_byte <= 9'h000;
        rx_partial <= 1'b0;
        rx_error <= 1'b0;
        rx_end <= 1'b0;
        rx_char_gap <= 1'b0;
    end

    // Keep the latest word the reader sends
    always @(posedge pclk) begin
        if (tx_word_valid === 1'b1) begin
            last_word <= tx_word;
        end
    end

    // One-cycle frame event: 0 start, 1 error, 2 end
    task automatic strobe(input int kind);
        @(posedge pclk);
        rx_sof <= (kind == 0);
        rx_error <= (kind == 1);
        rx_end <= (kind == 2);
        @(posedge pclk);
        rx_sof <= 1'b0;
        rx_error <= 1'b0;
        rx_end <= 1'b0;
    endtask

    // Byte with odd parity, or flipped parity; data line inverted after
    task automatic send_byte(input logic [7:0] b, input logic good);
        @(posedge pclk);
        rx_byte <= {(~^b) ^ ~good, b};
        rx_byte_valid <= 1'b1;
        @(posedge pclk);
        rx_byte <= ~{(~^b) ^ ~good, b};
        rx_byte_valid <= 1'b0;
    endtask

    // Trailing incomplete byte, no parity bit
    task automatic send_part(input logic [7:0] b);
        @(posedge pclk);
        rx_byte <= {1'b0, b};
        rx_partial <= 1'b1;
        rx_byte_valid <= 1'b1;
        @(posedge pclk);
        rx_byte <= ~{1'b0, b};
        rx_partial <= 1'b0;
        rx_byte_valid <= 1'b0;
    endtask

    // Character gap held for a number of cycles
    task automatic char_gap(input int cycles);
        @(posedge pclk);
        rx_char_gap <= 1'b1;
        repeat (cycles) @(posedge pclk);
        rx_char_gap <= 1'b0;
    endtask

    // Live subcarrier level
    task automatic subcarrier(input logic v);
        @(posedge pclk);
        rx_subcarrier <= v;
    endtask
endmodule
`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rfg_params.svh"
module testbench;
    import rfg_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic pce = 1'b1;
    logic crc_enable = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000, prdata;
    logic pready, pslverr, err;
    logic tx_request = 1'b0, tx_last = 1'b0, tx_byte_done = 1'b0, half_bit_tick = 1'b0;
    logic [7:0] tx_byte = 8'h00, fifo_data, rd, last_fifo;
    logic rx_sof, rx_subcarrier, rx_byte_valid, rx_partial, rx_error, rx_end, rx_char_gap;
    logic [8:0] rx_byte, tx_word;
    logic tx_start, tx_symbol_valid, tx_word_valid, rx_parity_error, fifo_write, fifo_reset;
    logic rx_active, rx_irq, rx_frame_start_interrupt, protocol_error;
    logic eof_check_enable, eof_type_b;
    logic [2:0] rx_baud_code;
    logic [1:0] tdiv = 2'h0;
    rfg_sym_t tx_symbol;
    rfg_sym_t sym_q[$];
    int num_errors = 0, total_checks = 0;
    int n_fsi = 0, n_irq = 0, n_fw = 0, n_rst = 0, n_perr = 0, n_pe = 0, n_tick = 0, cyc = 0;
    int b0, b1, t_done, c_done;

    rfg_frame_guard u_rfg_frame_guard (.pclk, .presetn, .pce, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_request, .tx_byte, .tx_last,
        .tx_byte_done, .half_bit_tick, .rx_sof, .rx_subcarrier, .rx_byte_valid, .rx_byte,
        .rx_partial, .rx_error, .rx_end, .rx_char_gap, .crc_enable, .tx_start, .tx_symbol,
        .tx_symbol_valid, .tx_word, .tx_word_valid, .rx_parity_error, .fifo_write,
        .fifo_data, .fifo_reset, .rx_active, .rx_irq, .rx_frame_start_interrupt,
        .protocol_error, .eof_check_enable, .eof_type_b, .rx_baud_code);
    rfg_card_model u_rfg_card_model (.pclk, .tx_word, .tx_word_valid, .rx_sof,
        .rx_subcarrier, .rx_byte_valid, .rx_byte, .rx_partial, .rx_error, .rx_end,
        .rx_char_gap);

    always #2 pclk = ~pclk;

    // Half-bit ticks every fourth cycle, event counters
    always @(posedge pclk) begin
        cyc++;
        tdiv <= tdiv + 2'h1;
        half_bit_tick <= (tdiv == 2'h3);
        if (half_bit_tick === 1'b1) n_tick++;
        if (rx_frame_start_interrupt === 1'b1) n_fsi++;
        if (rx_irq === 1'b1) n_irq++;
        if (rx_parity_error === 1'b1) n_perr++;
        if (protocol_error === 1'b1) n_pe++;
        if (fifo_reset === 1'b1) n_rst++;
        if (fifo_write === 1'b1) n_fw++;
        if (fifo_write === 1'b1) last_fifo = fifo_data;
        if (tx_symbol_valid === 1'b1 && tx_symbol !== RFG_SYM_NONE) sym_q.push_back(tx_symbol);
    end

    // ==========================================
    // Tasks
    task automatic complete_run();
        if (num_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {22'h0, idx, 2'b00};
        pwdata <= {24'h00_0000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata[7:0];
        err = pslverr;
        if (n >= 50) chk(32'h0, 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        apb(1'b1, idx, v);
    endtask

    task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(32'({err, rd}), 32'(exp));
    endtask

    task automatic settle();
        repeat (3) @(posedge pclk);
    endtask

    // One-byte frame; returns ticks and cycles since the last frame ended
    task automatic send_frame(input logic [7:0] b, output int ticks, output int cycles);
        int n;
        n = 0;
        tx_request <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (tx_start !== 1'b1 && n < 4000);
        if (n >= 4000) chk(32'h0, 32'h1);
        ticks = n_tick - t_done;
        cycles = cyc - c_done;
        tx_request <= 1'b0;
        repeat (3) @(posedge pclk);
        tx_byte <= b;
        tx_last <= 1'b1;
        tx_byte_done <= 1'b1;
        @(posedge pclk);
        t_done = n_tick;
        c_done = cyc;
        tx_byte_done <= 1'b0;
        tx_last <= 1'b0;
        repeat (6) @(posedge pclk);
        chk(32'(u_rfg_card_model.last_word), {23'h0, ~^b, b});
    endtask

    // Hang guard
    initial begin
        #200_000;
        num_errors++;
        complete_run();
    end

    // ==========================================
    // Main sequence
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(`RFG_IDX_GUARD_CTRL, 8'hC0);
        rchk(`RFG_IDX_GUARD_LOW, 8'h00);
        rchk(`RFG_IDX_FRAME_FMT, 8'h00);
        rchk(`RFG_IDX_SOF_DET, 8'h00);
        apb(1'b0, 8'h40, 8'h00);
        chk(32'({err, rd}), 32'h0000_0100);
        for (int c = 2; c < 8; c++) begin
            wr(`RFG_IDX_RX_CTRL, 8'(c));
            settle();
            chk(32'(rx_baud_code), 32'(c));
        end
        rchk(`RFG_IDX_RX_CTRL, 8'h07);
        wr(`RFG_IDX_RX_CTRL, 8'h20);
        settle();
        chk(32'({eof_type_b, eof_check_enable}), 32'h0000_0003);
        wr(`RFG_IDX_RX_CTRL, 8'h00);
        for (int s = 0; s < 4; s++) begin
            wr(`RFG_IDX_EOF_SYM, 8'(s));
            settle();
            chk(32'({eof_type_b, eof_check_enable}), 32'(s != 0));
        end
        // Subcarrier flags and interrupt
        wr(`RFG_IDX_SOF_DET, 8'h04);
        b0 = n_fsi;
        u_rfg_card_model.subcarrier(1'b1);
        settle();
        chk(32'(n_fsi != b0), 32'h0000_0001);
        rchk(`RFG_IDX_SOF_DET, 8'h07);
        u_rfg_card_model.subcarrier(1'b0);
        settle();
        rchk(`RFG_IDX_SOF_DET, 8'h06);
        wr(`RFG_IDX_SOF_DET, 8'h02);
        rchk(`RFG_IDX_SOF_DET, 8'h00);
        // Start-of-frame flag and interrupt
        wr(`RFG_IDX_SOF_DET, 8'h20);
        b0 = n_fsi;
        u_rfg_card_model.strobe(0);
        settle();
        chk(32'(n_fsi - b0), 32'h0000_0001);
        rchk(`RFG_IDX_SOF_DET, 8'h30);
        wr(`RFG_IDX_SOF_DET, 8'h30);
        rchk(`RFG_IDX_SOF_DET, 8'h20);
        // Clock enable low freezes the detector flags
        b0 = n_fsi;
        pce <= 1'b0;
        u_rfg_card_model.strobe(0);
        settle();
        pce <= 1'b1;
        chk(32'(n_fsi - b0), 32'h0000_0000);
        rchk(`RFG_IDX_SOF_DET, 8'h20);
        // Parity strip, multi-frame error byte
        wr(`RFG_IDX_FRAME_FMT, 8'h40);
        wr(`RFG_IDX_RX_CTRL, 8'h40);
        u_rfg_card_model.strobe(0);
        b0 = n_fw;
        u_rfg_card_model.send_byte(8'hA5, 1'b1);
        settle();
        chk(32'({n_fw - b0, last_fifo}), 32'h0000_01A5);
        b1 = n_perr;
        u_rfg_card_model.send_byte(8'h3C, 1'b0);
        settle();
        chk(32'(n_perr - b1), 32'h0000_0001);
        b0 = n_fw;
        u_rfg_card_model.strobe(2);
        settle();
        chk(32'({n_fw - b0, last_fifo}), 32'h0000_0102);
        chk(32'(rx_active), 32'h0000_0001);
        // Disturbance suppression
        wr(`RFG_IDX_RX_CTRL, 8'h08);
        b0 = n_rst;
        b1 = n_irq;
        u_rfg_card_model.strobe(0);
        u_rfg_card_model.send_byte(8'h11, 1'b1);
        u_rfg_card_model.strobe(1);
        settle();
        chk(32'(n_rst - b0), 32'h0000_0001);
        u_rfg_card_model.strobe(2);
        settle();
        chk(32'(n_irq - b1), 32'h0000_0000);
        u_rfg_card_model.strobe(0);
        for (int i = 0; i < 3; i++) u_rfg_card_model.send_byte(8'(i), 1'b1);
        u_rfg_card_model.strobe(2);
        settle();
        chk(32'(n_irq - b1), 32'h0000_0001);
        // Partial byte with checksum on, then gap check for type B
        crc_enable <= 1'b1;
        b0 = n_fw;
        u_rfg_card_model.send_part(8'h0F);
        settle();
        chk(32'(n_fw - b0), 32'h0000_0000);
        wr(`RFG_IDX_RX_CTRL, 8'h88);
        b0 = n_fw;
        u_rfg_card_model.send_part(8'h0E);
        settle();
        chk(32'({n_fw - b0, last_fifo}), 32'h0000_010E);
        crc_enable <= 1'b0;
        wr(`RFG_IDX_RX_CTRL, 8'h30);
        b0 = n_pe;
        u_rfg_card_model.char_gap(520);
        settle();
        chk(32'(n_pe - b0), 32'h0000_0001);
        wr(`RFG_IDX_RX_CTRL, 8'h20);
        u_rfg_card_model.char_gap(520);
        settle();
        chk(32'(n_pe - b0), 32'h0000_0001);
        rchk(`RFG_IDX_ERROR, 8'h04);
        // Transmit symbols and guard in half-bit units (value 258)
        wr(`RFG_IDX_GUARD_LOW, 8'h02);
        wr(`RFG_IDX_GUARD_CTRL, 8'h48);
        rchk(`RFG_IDX_GUARD_CTRL, 8'h48);
        for (int k = 0; k < 4; k++) begin
            wr(`RFG_IDX_FRAME_FMT, 8'(128 + 4 * (3 - k) + k));
            sym_q.delete();
            send_frame(8'h5A + 8'(k), b0, b1);
            if (k > 0) chk(32'(b0 >= 258 && b0 <= 260), 32'h0000_0001);
            chk(32'(sym_q.size()), 32'(2 - (k == 0 || k == 3)));
            if (k > 0) chk(32'(sym_q[0]), 32'(k));
            if (k < 3) chk(32'(sym_q[sym_q.size() - 1]), 32'(3 - k));
        end
        // Let the half-bit guard run out before switching units
        repeat (1100) @(posedge pclk);
        // Carrier unit, guard value 1, counted from end of transmit
        wr(`RFG_IDX_GUARD_CTRL, 8'h00);
        wr(`RFG_IDX_GUARD_LOW, 8'h01);
        send_frame(8'h01, b0, b1);
        send_frame(8'h02, b0, b1);
        chk(32'(b1 >= 295 && b1 <= 299), 32'h0000_0001);
        // Guard counted from end of receive: transmit end does not load it
        wr(`RFG_IDX_GUARD_CTRL, 8'h80);
        send_frame(8'h03, b0, b1);
        send_frame(8'h04, b0, b1);
        chk(32'(b1 < 20), 32'h0000_0001);
        complete_run();
    end
endmodule
`default_nettype wire
